// ==== rtl/mcps_defines.svh ====
// Overview of operation
// [R1] Master clock is selected source divided 2..16
// [R2] First stage runs at twice master rate
// [R3] Companion core clock comes from same source
// [R4] Firmware keeps 11 Mb/s master within 11-16 MHz
// [R5] Master up to 25 MHz, input 50 MHz
// [R6] Reset loads divide ratio of sixteen
// [R7] Divisor changes never make runt pulses
// [R8] Fast and slow strobes switch source glitch-free
// [R9] Reset falls back to slow when input dead
// [R10] Detector runs on slow clock; no crystal, no fallback
// [R11] Slow clock drives sleep interval wake-up timer
// [R12] Firmware times oscillator start before going fast
// [R13] Support full 2..16 ratio range, not 2..14
// [R14] New settings apply only at period end
`ifndef MCPS_DEFINES_SVH
`define MCPS_DEFINES_SVH

// Divide ratio, in source half periods per master half period
`define MCPS_RATIO_W 5
`define MCPS_RATIO_MIN 5'h02
`define MCPS_RATIO_MAX 5'h10
`define MCPS_RATIO_RESET 5'h10
// Slow clock periods without an input edge before fallback
`define MCPS_MISS_W 2
`define MCPS_MISS_ALL 2'h3
// Sleep interval counter, in slow clock periods
`define MCPS_TIMER_W 16
`define MCPS_TIMER_ONE 16'h0001
`define MCPS_TIMER_ZERO 16'h0000
// Source index into the synchroniser array
`define MCPS_SRC_IDX_FAST 0
`define MCPS_SRC_IDX_SLOW 1
`define MCPS_NUM_SRC 2

`endif

// ==== rtl/mcps_edge_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser with edge detection on the settled copy.
// No reset: it must keep sampling while the chip is held in reset.
module mcps_edge_sync (
  input wire logic clk,
  input wire logic async_in,
  output logic rise,
  output logic toggle
);
  logic meta_q; // First stage, read only by the second
  logic sync_q; // Settled copy
  logic last_q; // Previous settled value for edge detection
  logic meta_d;
  logic sync_d;
  logic last_d;

  // Next values of the pipeline
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
    last_d = sync_q;
  end

  // Register the pipeline
  always_ff @(posedge clk) begin
    meta_q <= meta_d;
    sync_q <= sync_d;
    last_q <= last_d;
  end

  // Edge pulses, one clk cycle each
  assign rise = sync_q & ~last_q;
  assign toggle = sync_q ^ last_q;
endmodule : mcps_edge_sync
`default_nettype wire

// ==== rtl/mcps_pkg.sv ====
package mcps_pkg;
  // Clock source in use by the divider
  typedef enum logic {MCPS_SRC_FAST, MCPS_SRC_SLOW} mcps_src_t;
endpackage : mcps_pkg

// ==== rtl/mcps_sleep_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mcps_defines.svh"
// Interval timer counted in slow clock periods, wake pulse at expiry
module mcps_sleep_timer (
  input wire logic clk,
  input wire logic nrst,
  input wire logic lf_tick,
  input wire logic arm,
  input wire logic [`MCPS_TIMER_W-1:0] interval,
  output logic wake,
  output logic busy
);
  logic [`MCPS_TIMER_W-1:0] count_q, count_d; // Remaining periods
  logic busy_q, busy_d; // Interval running
  logic wake_q, wake_d; // Expiry pulse

  // Arm reloads; each slow tick counts down; last tick wakes
  always_comb begin
    count_d = count_q;
    busy_d = busy_q;
    wake_d = 1'b0;
    if (arm) begin
      // A zero interval never runs, so no spurious wake
      count_d = interval;
      busy_d = (interval != `MCPS_TIMER_ZERO);
    end else if (busy_q && lf_tick) begin // [R11]
      if (count_q == `MCPS_TIMER_ONE) begin
        busy_d = 1'b0;
        wake_d = 1'b1;
      end
      count_d = count_q - `MCPS_TIMER_ONE;
    end
  end

  // Register timer state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_q <= `MCPS_TIMER_ZERO;
      busy_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      count_q <= count_d;
      busy_q <= busy_d;
      wake_q <= wake_d;
    end
  end

  assign wake = wake_q;
  assign busy = busy_q;

  // Wake is a single cycle and ends the interval
  a_wake_single: assert property (@(posedge clk) disable iff (!nrst) // [R11]
    wake_q |-> !busy_q ##1 !wake_q)
    else $error("wake pulse not single or timer still busy");
  // Expiry follows the last tick of a running interval
  a_wake_cause: assert property (@(posedge clk) disable iff (!nrst) // [R11]
    busy_q && lf_tick && !arm && count_q == `MCPS_TIMER_ONE |=> wake_q)
    else $error("timer expired without wake");
endmodule : mcps_sleep_timer
`default_nettype wire

// ==== rtl/mcps_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mcps_defines.svh"
// Master clock prescaler with source selection and sleep timer.
// The divider counts both edges of the selected source, so one count
// is a half source period; a first stage pulse every ratio counts
// gives twice the master rate, and the master output toggles on it.
module mcps_top
  import mcps_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic external_clock_input,
  input wire logic lf_clock_input,
  input wire logic strobe_fast,
  input wire logic strobe_slow,
  input wire logic divisor_wr,
  input wire logic [`MCPS_RATIO_W-1:0] divisor_wdata,
  input wire logic timer_arm,
  input wire logic [`MCPS_TIMER_W-1:0] timer_interval,
  output logic master_clock,
  output logic companion_core_clock,
  output logic [`MCPS_RATIO_W-1:0] divisor_in_force,
  output logic source_is_slow,
  output logic wake_up,
  output logic sleep_timer_busy
);

  // Legal divide ratio check, used by the write path and its check
  function automatic logic ratio_ok(input logic [`MCPS_RATIO_W-1:0] r);
    ratio_ok = (r >= `MCPS_RATIO_MIN) && (r <= `MCPS_RATIO_MAX);
  endfunction : ratio_ok

  logic [`MCPS_NUM_SRC-1:0] src_pin; // Raw source pins
  logic [`MCPS_NUM_SRC-1:0] src_rise; // Rising edge pulses
  logic [`MCPS_NUM_SRC-1:0] src_toggle; // Any edge pulses

  assign src_pin[`MCPS_SRC_IDX_FAST] = external_clock_input;
  assign src_pin[`MCPS_SRC_IDX_SLOW] = lf_clock_input;

  // One synchroniser per source pin
  genvar gi;
  generate
    for (gi = 0; gi < `MCPS_NUM_SRC; gi++) begin : g_sync
      mcps_edge_sync u_sync (
        .clk(clk),
        .async_in(src_pin[gi]),
        .rise(src_rise[gi]),
        .toggle(src_toggle[gi])
      );
    end
  endgenerate

  logic fast_toggle; // Any edge of the external clock
  logic lf_tick; // Rising edge of the slow clock
  // Sampling at 200 MHz still sees every edge of a 50 MHz input
  assign fast_toggle = src_toggle[`MCPS_SRC_IDX_FAST]; // [R5]
  assign lf_tick = src_rise[`MCPS_SRC_IDX_SLOW];

  // Missing-clock detector. Not reset by nrst on purpose: it has to
  // run while the chip is held in reset. Each slow rising edge shifts
  // in a one, any external edge clears it; both bits set means two
  // slow periods passed quietly. Without a crystal it never fills.
  logic [`MCPS_MISS_W-1:0] miss_q, miss_d;
  logic init_q, init_d; // High through reset and the first cycle after

  // Next value of the detector. It gathers only while init_q is up,
  // so each reset starts from empty; a count left from an earlier
  // reset would otherwise force a fallback with no crystal fitted.
  always_comb begin
    miss_d = miss_q;
    if (!init_q) begin
      miss_d = '0;
    end else if (fast_toggle) begin
      miss_d = '0;
    end else if (lf_tick) begin // [R10]
      miss_d = {miss_q[`MCPS_MISS_W-2:0], 1'b1};
    end
  end

  // Register the detector on the system clock
  always_ff @(posedge clk) begin
    miss_q <= miss_d;
  end

  // Control state of the divider
  mcps_src_t sel_q, sel_d; // Source in force
  mcps_src_t pend_src_q, pend_src_d; // Requested source
  logic pend_src_v_q, pend_src_v_d; // Source request waiting
  logic [`MCPS_RATIO_W-1:0] ratio_q, ratio_d; // Ratio in force
  logic [`MCPS_RATIO_W-1:0] pend_ratio_q, pend_ratio_d; // Requested ratio
  logic pend_ratio_v_q, pend_ratio_v_d; // Ratio request waiting
  logic [`MCPS_RATIO_W-1:0] hcnt_q, hcnt_d; // Half periods counted
  logic master_q, master_d; // Master clock output
  logic core_q, core_d; // Companion core clock output
  logic src_edge; // Edge of the selected source
  logic [`MCPS_RATIO_W-1:0] hcnt_inc; // Count after this edge
  logic stage_pulse; // First stage output, twice master rate
  logic core_pulse; // Midpoint between first stage pulses
  logic boundary; // End of a complete master period

  // Edge selection and first stage decode
  always_comb begin
    src_edge = (sel_q == MCPS_SRC_FAST) ? fast_toggle : src_toggle[`MCPS_SRC_IDX_SLOW];
    hcnt_inc = hcnt_q + `MCPS_RATIO_W'(1);
    stage_pulse = src_edge && (hcnt_inc == ratio_q); // [R2]
    core_pulse = src_edge && (hcnt_inc == (ratio_q >> 1)); // [R3]
    // Master falls here, so a change now cannot shorten any phase
    boundary = stage_pulse && master_q; // [R7]
  end

  // Next values of selection, ratio and divider
  always_comb begin
    sel_d = sel_q;
    pend_src_d = pend_src_q;
    pend_src_v_d = pend_src_v_q;
    ratio_d = ratio_q;
    pend_ratio_d = pend_ratio_q;
    pend_ratio_v_d = pend_ratio_v_q;
    hcnt_d = hcnt_q;
    master_d = master_q;
    core_d = core_q;
    init_d = 1'b0;

    // Strobes only record a request; slow wins if both arrive together
    if (strobe_slow) begin // [R8]
      pend_src_d = MCPS_SRC_SLOW;
      pend_src_v_d = 1'b1;
    end else if (strobe_fast) begin // [R8]
      pend_src_d = MCPS_SRC_FAST;
      pend_src_v_d = 1'b1;
    end

    // Out-of-range ratios are ignored, the full 2..16 is accepted
    if (divisor_wr && ratio_ok(divisor_wdata)) begin // [R1] [R13]
      pend_ratio_d = divisor_wdata;
      pend_ratio_v_d = 1'b1;
    end

    // Divider: toggle master per first stage pulse
    // Counting both source edges is what keeps odd ratios at 50% duty
    if (stage_pulse) begin // [R2]
      hcnt_d = '0;
      master_d = ~master_q;
    end else if (src_edge) begin
      hcnt_d = hcnt_inc;
    end

    // Companion clock leads master by ratio_q - (ratio_q >> 1) source half periods
    if (core_pulse) begin // [R3]
      core_d = ~core_q;
    end

    // Apply waiting requests at a completed period only
    if (boundary) begin // [R14]
      if (pend_ratio_v_q) begin // [R7]
        ratio_d = pend_ratio_q;
        // A write landing in this very cycle waits for the next period
        pend_ratio_v_d = divisor_wr && ratio_ok(divisor_wdata);
      end
      if (pend_src_v_q) begin // [R8]
        sel_d = pend_src_q;
        // A strobe in this very cycle is kept, the set wins
        pend_src_v_d = strobe_fast || strobe_slow;
      end
      // Realign the quadrature clock with the new period
      core_d = 1'b0;
    end

    // Latch the fallback decision caught during reset
    if (init_q) begin // [R9]
      sel_d = (miss_q == `MCPS_MISS_ALL) ? MCPS_SRC_SLOW : MCPS_SRC_FAST;
    end
  end

  // Register control state; reset ratio lets boot code run slowly
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sel_q <= MCPS_SRC_FAST;
      pend_src_q <= MCPS_SRC_FAST;
      pend_src_v_q <= 1'b0;
      ratio_q <= `MCPS_RATIO_RESET; // [R6]
      pend_ratio_q <= `MCPS_RATIO_RESET;
      pend_ratio_v_q <= 1'b0;
      hcnt_q <= '0;
      master_q <= 1'b0;
      core_q <= 1'b0;
      init_q <= 1'b1;
    end else begin
      sel_q <= sel_d;
      pend_src_q <= pend_src_d;
      pend_src_v_q <= pend_src_v_d;
      ratio_q <= ratio_d;
      pend_ratio_q <= pend_ratio_d;
      pend_ratio_v_q <= pend_ratio_v_d;
      hcnt_q <= hcnt_d;
      master_q <= master_d;
      core_q <= core_d;
      init_q <= init_d;
    end
  end

  // Sleep interval timer on the slow clock
  logic wake_w;
  logic busy_w;
  mcps_sleep_timer u_timer (
    .clk(clk),
    .nrst(nrst),
    .lf_tick(lf_tick),
    .arm(timer_arm),
    .interval(timer_interval),
    .wake(wake_w),
    .busy(busy_w)
  );

  // Outputs, all straight from flip-flops
  assign master_clock = master_q;
  assign companion_core_clock = core_q;
  assign divisor_in_force = ratio_q; // [R14]
  assign source_is_slow = (sel_q == MCPS_SRC_SLOW);
  assign wake_up = wake_w;
  assign sleep_timer_busy = busy_w;

  // Period end sequence: a first stage pulse while master is high
  sequence s_period_end;
    stage_pulse && master_q;
  endsequence

  // Request waiting followed by the period end that applies it
  sequence s_ratio_apply;
    pend_ratio_v_q ##0 s_period_end;
  endsequence

  a_reset_ratio: assert property (@(posedge clk) disable iff (!nrst) // [R6]
    init_q |-> ratio_q == `MCPS_RATIO_RESET)
    else $error("ratio not sixteen after reset");

  a_ratio_range: assert property (@(posedge clk) disable iff (!nrst) // [R1]
    ratio_ok(ratio_q))
    else $error("ratio in force outside 2..16");

  a_ratio_apply: assert property (@(posedge clk) disable iff (!nrst) // [R14]
    s_ratio_apply |=> ratio_q == $past(pend_ratio_q))
    else $error("waiting ratio not applied at period end");

  a_ratio_only_end: assert property (@(posedge clk) disable iff (!nrst) // [R7]
    !boundary |=> $stable(ratio_q))
    else $error("ratio changed inside a period");

  a_src_only_end: assert property (@(posedge clk) disable iff (!nrst) // [R8]
    !boundary && !init_q |=> $stable(sel_q))
    else $error("source changed inside a period");

  a_master_toggle: assert property (@(posedge clk) disable iff (!nrst) // [R2]
    stage_pulse |=> master_q != $past(master_q))
    else $error("master did not toggle on first stage pulse");

  a_master_hold: assert property (@(posedge clk) disable iff (!nrst) // [R7]
    !stage_pulse |=> $stable(master_q))
    else $error("master changed without first stage pulse");

  a_core_toggle: assert property (@(posedge clk) disable iff (!nrst) // [R3]
    core_pulse && !boundary |=> core_q != $past(core_q))
    else $error("companion clock missed its midpoint");

  a_fallback_slow: assert property (@(posedge clk) disable iff (!nrst) // [R9]
    init_q && miss_q == `MCPS_MISS_ALL |=> source_is_slow)
    else $error("no fallback with dead external clock");

  a_no_crystal_fast: assert property (@(posedge clk) disable iff (!nrst) // [R10]
    init_q && miss_q != `MCPS_MISS_ALL |=> !source_is_slow)
    else $error("fallback without two quiet slow periods");

  // Source request waiting followed by the period end that applies it
  sequence s_src_apply;
    pend_src_v_q && !init_q ##0 s_period_end;
  endsequence

  a_src_apply: assert property (@(posedge clk) disable iff (!nrst) // [R8]
    s_src_apply |=> sel_q == $past(pend_src_q))
    else $error("waiting source not applied at period end");

  a_core_hold: assert property (@(posedge clk) disable iff (!nrst) // [R3]
    !core_pulse && !boundary |=> $stable(core_q))
    else $error("companion clock changed off its midpoint");

  a_count_bound: assert property (@(posedge clk) disable iff (!nrst) // [R7]
    hcnt_q < ratio_q)
    else $error("half period count passed the ratio");

  a_miss_clear: assert property (@(posedge clk) disable iff (!nrst) // [R9]
    fast_toggle |=> miss_q == '0)
    else $error("external edge did not clear detector");

  a_miss_idle: assert property (@(posedge clk) disable iff (!nrst) // [R10]
    !init_q |=> miss_q == '0)
    else $error("detector holds counts outside reset");

  a_init_once: assert property (@(posedge clk) disable iff (!nrst) // [R9]
    init_q |=> !init_q)
    else $error("fallback decision repeated after reset");
endmodule : mcps_top
`default_nettype wire

// ==== testbench/mcps_top_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mcps_defines.svh"
module mcps_top_bench;
  import mcps_pkg::*;
  // Slow source sped up; the design counts edges, not time
  time ext_half = 20; // Halved by the top rate scenario
  localparam time lf_half = 200;
  logic clk = 0;
  logic nrst = 0;
  logic ext_clock = 0;
  logic lf_clock = 0;
  logic ext_en = 1;
  logic lf_en = 1;
  logic strobe_fast = 0;
  logic strobe_slow = 0;
  logic divisor_wr = 0;
  logic [`MCPS_RATIO_W-1:0] divisor_wdata = 5'h10;
  logic timer_arm = 0;
  logic [`MCPS_TIMER_W-1:0] timer_interval = 16'h0000;
  logic master_clock;
  logic companion_core_clock;
  logic [`MCPS_RATIO_W-1:0] divisor_in_force;
  logic source_is_slow;
  logic wake_up;
  logic sleep_timer_busy;
  logic use_core = 0;
  wire meas_clk = use_core ? companion_core_clock : master_clock;
  int errors = 0;
  int checks_done = 0;
  int i;
  time per;
  time hi;

  mcps_top dut (
    .clk(clk), .nrst(nrst), .external_clock_input(ext_clock),
    .lf_clock_input(lf_clock), .strobe_fast(strobe_fast),
    .strobe_slow(strobe_slow), .divisor_wr(divisor_wr),
    .divisor_wdata(divisor_wdata), .timer_arm(timer_arm),
    .timer_interval(timer_interval), .master_clock(master_clock),
    .companion_core_clock(companion_core_clock),
    .divisor_in_force(divisor_in_force), .source_is_slow(source_is_slow),
    .wake_up(wake_up), .sleep_timer_busy(sleep_timer_busy)
  );

  // System clock
  always #2.5 clk = ~clk;
  // Fast source; a stopped source just holds its level
  always begin
    #(ext_half);
    if (ext_en) ext_clock = ~ext_clock;
  end
  // Slow source; stands low when no crystal is fitted
  always begin
    #(lf_half);
    lf_clock = lf_en ? ~lf_clock : 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val

  task automatic chk_time(input string what, input time exp, input time got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %0t seen %0t", what, exp, got);
    end
  endtask : chk_time

  // Second full cycle after the call, so a realignment is skipped
  task automatic meas(output time p, output time h);
    time t0;
    @(posedge meas_clk);
    @(posedge meas_clk);
    t0 = $time;
    @(negedge meas_clk);
    h = $time - t0;
    @(posedge meas_clk);
    p = $time - t0;
  endtask : meas

  task automatic set_div(input logic [4:0] v);
    divisor_wdata = v;
    divisor_wr = 1;
    tick(1);
    divisor_wr = 0;
    tick(1);
  endtask : set_div

  task automatic wait_div(input logic [4:0] v);
    for (i = 0; i < 400 && divisor_in_force !== v; i++) tick(1);
  endtask : wait_div

  task automatic wait_src(input logic v);
    for (i = 0; i < 2000 && source_is_slow !== v; i++) tick(1);
  endtask : wait_src

  task automatic test_reset_values;
    chk_val("divisor after reset", 16'h0010, 16'(divisor_in_force));
    chk_val("source after reset", 16'h0000, 16'(source_is_slow));
    meas(per, hi);
    chk_time("reset master period", 16 * 2 * ext_half, per);
  endtask : test_reset_values

  task automatic test_ratio;
    set_div(5'h03);
    wait_div(5'h03);
    chk_val("divisor three", 16'h0003, 16'(divisor_in_force));
    // Out of range writes leave the ratio alone
    set_div(5'h11);
    set_div(5'h01);
    tick(300);
    chk_val("divisor kept", 16'h0003, 16'(divisor_in_force));
    meas(per, hi);
    chk_time("master period 3", 3 * 2 * ext_half, per);
    chk_time("master high 3", 3 * ext_half, hi);
    use_core = 1;
    meas(per, hi);
    use_core = 0;
    chk_time("core period 3", 3 * 2 * ext_half, per);
    // Back to back writes: the later one wins
    set_div(5'h10);
    set_div(5'h02);
    wait_div(5'h02);
    tick(400);
    chk_val("divisor last wins", 16'h0002, 16'(divisor_in_force));
    meas(per, hi);
    chk_time("master period 2", 2 * 2 * ext_half, per);
  endtask : test_ratio

  task automatic test_source;
    strobe_slow = 1;
    tick(1);
    strobe_slow = 0;
    wait_src(1'b1);
    chk_val("slow selected", 16'h0001, 16'(source_is_slow));
    meas(per, hi);
    chk_time("slow master period", 2 * 2 * lf_half, per);
    // Time the fast oscillator start on the sleep timer first
    timer_interval = 16'h0001;
    timer_arm = 1;
    tick(1);
    timer_arm = 0;
    for (i = 0; i < 300 && wake_up !== 1'b1; i++) tick(1);
    chk_val("start-up wait", 16'h0001, 16'(wake_up));
    strobe_fast = 1;
    tick(1);
    strobe_fast = 0;
    wait_src(1'b0);
    chk_val("fast selected", 16'h0000, 16'(source_is_slow));
  endtask : test_source

  task automatic test_timer;
    timer_interval = 16'h0002;
    timer_arm = 1;
    tick(1);
    timer_arm = 0;
    chk_val("timer busy", 16'h0001, 16'(sleep_timer_busy));
    for (i = 0; i < 300 && wake_up !== 1'b1; i++) tick(1);
    chk_val("wake pulse", 16'h0001, 16'(wake_up));
    chk_val("busy at wake", 16'h0000, 16'(sleep_timer_busy));
    // Zero interval stops a running timer without a wake
    timer_interval = 16'h0003;
    timer_arm = 1;
    tick(1);
    timer_arm = 0;
    tick(1);
    chk_val("timer rearmed", 16'h0001, 16'(sleep_timer_busy));
    timer_interval = 16'h0000;
    timer_arm = 1;
    tick(1);
    timer_arm = 0;
    for (i = 0; i < 300 && wake_up !== 1'b1; i++) tick(1);
    chk_val("timer stopped", 16'h0000, 16'(sleep_timer_busy));
    chk_val("no wake after stop", 16'h0000, 16'(wake_up));
  endtask : test_timer

  // Fastest input with the smallest ratio gives the top master rate
  task automatic test_max_rate;
    ext_half = 10;
    tick(20);
    meas(per, hi);
    chk_time("max rate period", 2 * 2 * ext_half, per);
    chk_time("max rate high", 2 * ext_half, hi);
    ext_half = 20;
    tick(20);
  endtask : test_max_rate

  // Long reset with the fast source dead, with and without a crystal
  task automatic test_fallback;
    ext_en = 0;
    nrst = 0;
    tick(200);
    nrst = 1;
    tick(2);
    chk_val("fallback to slow", 16'h0001, 16'(source_is_slow));
    meas(per, hi);
    chk_time("fallback period", 16 * 2 * lf_half, per);
    lf_en = 0;
    nrst = 0;
    tick(200);
    nrst = 1;
    tick(2);
    chk_val("no crystal keeps fast", 16'h0000, 16'(source_is_slow));
    ext_en = 1;
    lf_en = 1;
  endtask : test_fallback

  task automatic finish_test;
    if (errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    #1;
    nrst = 1;
    tick(2);
    test_reset_values;
    test_ratio;
    test_max_rate;
    test_source;
    test_timer;
    test_fallback;
    finish_test;
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    finish_test;
  end
endmodule : mcps_top_bench
`default_nettype wire
